/* src/rxbf_top.v */
`timescale 1ns/100ps
`include "rxbf_defs.vh"

module rxbf_top (
	input wire sys_clk_in, // Device clock, 50 MHz
	input wire reset_in, // Synchronous reset, active high
	input wire [7:0] reg_addr_in, // Register address from host port
	input wire reg_wr_in, // Register write strobe
	input wire [7:0] reg_wdata_in, // Write data
	input wire reg_rd_in, // Register read strobe
	output reg [7:0] reg_rdata_out, // Read data, registered
	input wire load0_in, // Valid message stored into buffer 0
	input wire load1_in, // Valid message stored into buffer 1
	input wire release0_in, // Buffer 0 freed by host
	input wire release1_in, // Buffer 1 freed by host
	input wire [10:0] rx_std_id_in, // Received standard identifier
	input wire [17:16] rx_ext_id_in, // Received extended identifier top bits
	input wire rx_remote_in, // Received frame was a remote request
	input wire rx_extended_in, // Received frame used extended format
	output wire buffer0_full_pin_out, // Buffer 0 pin output value
	output wire buffer0_full_pin_oe_out, // Buffer 0 pin output enable
	output wire buffer1_full_pin_out, // Buffer 1 pin output value
	output wire buffer1_full_pin_oe_out // Buffer 1 pin output enable
);
	reg [5:0] pin_ctrl_q;
	wire [7:0] id_high0;
	wire [7:0] id_low0;
	wire [7:0] id_high1;
	wire [7:0] id_low1;
	wire [7:0] pin_ctrl_view;

	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	always @(posedge sys_clk_in)
	begin
		if (reset_in)
			pin_ctrl_q <= `RXBF_PIN_CTRL_RESET;
		else if (reg_wr_in && hit(reg_addr_in, `RXBF_ADDR_PIN_CTRL))
			pin_ctrl_q <= reg_wdata_in[5:0];
		// Identifier registers ignore writes
	end

	// Level bits read zero while their pin is in interrupt mode
	assign pin_ctrl_view = {2'b00,
		pin_ctrl_q[`RXBF_BIT_PIN1_LEVEL] & ~pin_ctrl_q[`RXBF_BIT_PIN1_MODE],
		pin_ctrl_q[`RXBF_BIT_PIN0_LEVEL] & ~pin_ctrl_q[`RXBF_BIT_PIN0_MODE],
		pin_ctrl_q[3:0]};

	always @(posedge sys_clk_in)
	begin
		if (reset_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				`RXBF_ADDR_PIN_CTRL: reg_rdata_out <= pin_ctrl_view;
				`RXBF_ADDR_RX0_SIDH: reg_rdata_out <= id_high0;
				`RXBF_ADDR_RX0_SIDL: reg_rdata_out <= id_low0;
				`RXBF_ADDR_RX1_SIDH: reg_rdata_out <= id_high1;
				`RXBF_ADDR_RX1_SIDL: reg_rdata_out <= id_low1;
				default: reg_rdata_out <= 8'h00;
			endcase
		end
	end

	rxbf_pin_drive u_pin0 (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.enable_in(pin_ctrl_q[`RXBF_BIT_PIN0_ENABLE]),
		.mode_in(pin_ctrl_q[`RXBF_BIT_PIN0_MODE]),
		.level_in(pin_ctrl_q[`RXBF_BIT_PIN0_LEVEL]),
		.loaded_in(load0_in),
		.release_in(release0_in),
		.pin_out(buffer0_full_pin_out),
		.pin_oe_out(buffer0_full_pin_oe_out)
	);

	rxbf_pin_drive u_pin1 (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.enable_in(pin_ctrl_q[`RXBF_BIT_PIN1_ENABLE]),
		.mode_in(pin_ctrl_q[`RXBF_BIT_PIN1_MODE]),
		.level_in(pin_ctrl_q[`RXBF_BIT_PIN1_LEVEL]),
		.loaded_in(load1_in),
		.release_in(release1_in),
		.pin_out(buffer1_full_pin_out),
		.pin_oe_out(buffer1_full_pin_oe_out)
	);

	rxbf_id_store u_id0 (
		.sys_clk_in(sys_clk_in),
		.load_in(load0_in),
		.std_id_in(rx_std_id_in),
		.ext_id_in(rx_ext_id_in),
		.remote_in(rx_remote_in),
		.extended_in(rx_extended_in),
		.std_id_high_out(id_high0),
		.std_id_low_out(id_low0)
	);

	rxbf_id_store u_id1 (
		.sys_clk_in(sys_clk_in),
		.load_in(load1_in),
		.std_id_in(rx_std_id_in),
		.ext_id_in(rx_ext_id_in),
		.remote_in(rx_remote_in),
		.extended_in(rx_extended_in),
		.std_id_high_out(id_high1),
		.std_id_low_out(id_low1)
	);
endmodule // rxbf_top

/* src/rxbf_defs.vh */
`ifndef RXBF_DEFS_VH
`define RXBF_DEFS_VH

// Register addresses
`define RXBF_ADDR_PIN_CTRL 8'h0c
`define RXBF_ADDR_RX0_SIDH 8'h61
`define RXBF_ADDR_RX0_SIDL 8'h62
`define RXBF_ADDR_RX1_SIDH 8'h71
`define RXBF_ADDR_RX1_SIDL 8'h72

// Pin control field positions
`define RXBF_BIT_PIN1_LEVEL 5
`define RXBF_BIT_PIN0_LEVEL 4
`define RXBF_BIT_PIN1_ENABLE 3
`define RXBF_BIT_PIN0_ENABLE 2
`define RXBF_BIT_PIN1_MODE 1
`define RXBF_BIT_PIN0_MODE 0
`define RXBF_PIN_CTRL_RESET 6'h00

// Identifier low field positions
`define RXBF_SIDL_SRR_BIT 4
`define RXBF_SIDL_IDE_BIT 3

`endif

/* src/rxbf_pin_drive.v */
`timescale 1ns/100ps
`include "rxbf_defs.vh"

// One buffer-full pin: interrupt or plain output, tri-stated when disabled.
module rxbf_pin_drive (
	input wire sys_clk_in, // Device clock
	input wire reset_in, // Synchronous reset, active high
	input wire enable_in, // Pin function enable
	input wire mode_in, // 1 = interrupt, 0 = digital output
	input wire level_in, // Level in digital output mode
	input wire loaded_in, // Valid message loaded into this buffer
	input wire release_in, // Buffer freed by host
	output reg pin_out, // Pin output value
	output reg pin_oe_out // Pin output enable
);
	reg full_q;
	reg full_d;

	always @*
	begin
		full_d = full_q;
		if (release_in)
			full_d = 1'b0;
		// Set beats release so a load is never lost
		if (loaded_in)
			full_d = 1'b1;
	end

	always @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			full_q <= 1'b0;
			pin_out <= 1'b1;
			pin_oe_out <= 1'b0;
		end
		else
		begin
			full_q <= full_d;
			pin_oe_out <= enable_in;
			if (mode_in)
				pin_out <= ~full_d;
			else
				pin_out <= level_in;
		end
	end
endmodule // rxbf_pin_drive

/* src/rxbf_id_store.v */
`timescale 1ns/100ps
`include "rxbf_defs.vh"

// Identifier registers of one receive buffer, loaded on message store.
module rxbf_id_store (
	input wire sys_clk_in, // Device clock
	input wire load_in, // Store strobe for this buffer
	input wire [10:0] std_id_in, // Received standard identifier
	input wire [17:16] ext_id_in, // Top extended identifier bits
	input wire remote_in, // Remote request of received frame
	input wire extended_in, // Frame used extended format
	output reg [7:0] std_id_high_out, // Identifier high register
	output reg [7:0] std_id_low_out // Identifier low register
);
	// No reset: contents are undefined until the first message
	always @(posedge sys_clk_in)
	begin
		if (load_in)
		begin
			std_id_high_out <= std_id_in[10:3];
			std_id_low_out[7:5] <= std_id_in[2:0];
			// Standard-frame remote flag only; extended remote goes elsewhere
			std_id_low_out[`RXBF_SIDL_SRR_BIT] <= remote_in & ~extended_in;
			std_id_low_out[`RXBF_SIDL_IDE_BIT] <= extended_in;
			std_id_low_out[2] <= 1'b0;
			std_id_low_out[1:0] <= ext_id_in;
		end
	end
endmodule // rxbf_id_store

/* tb/rxbf_host.sv */
`timescale 1ns/100ps
module rxbf_host (
	input wire logic [1:0] pin_in, // Pin values, buffer 1 high
	input wire logic [1:0] oe_in, // Pin output enables
	output wire logic [1:0] line_out // Levels seen on the lines
);
	// Pull-ups on the lines, so a floating pin reads high
	assign line_out = {oe_in[1] ? pin_in[1] : 1'b1, oe_in[0] ? pin_in[0] : 1'b1};
endmodule // rxbf_host

/* tb/rxbf_top_asserts.sv */
`timescale 1ns/100ps
module rxbf_top_asserts (
	input wire logic sys_clk_in, reset_in, reg_wr_in, reg_rd_in, load0_in, load1_in, release0_in, release1_in,
	input wire logic rx_remote_in, rx_extended_in, buffer0_full_pin_out, buffer0_full_pin_oe_out,
	input wire logic buffer1_full_pin_out, buffer1_full_pin_oe_out,
	input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
	input wire logic [10:0] rx_std_id_in,
	input wire logic [17:16] rx_ext_id_in
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	wire w = reg_wr_in && reg_addr_in == 8'h0c;
	// Control lands one edge after the write, the pin register one edge later
	a_oe0_follows: assert property (w |-> ##2 buffer0_full_pin_oe_out == $past(reg_wdata_in[2], 2))
		else $error("oe0");
	a_level0_drive: assert property (w && reg_wdata_in[2:0] == 3'h4
		|-> ##2 buffer0_full_pin_out == $past(reg_wdata_in[4], 2)) else $error("lvl0");
	a_int1_load: assert property (w && reg_wdata_in[3] && reg_wdata_in[1] ##1 load1_in |=> !buffer1_full_pin_out)
		else $error("int1");
	a_unmapped_zero: assert property (reg_rd_in && reg_addr_in == 8'h55 |=> reg_rdata_out == 8'h00)
		else $error("unmapped");
	a_ctrl_top_zero: assert property (reg_rd_in && reg_addr_in == 8'h0c |=> reg_rdata_out[7:6] == 2'h0)
		else $error("ctrl");
	a_idlow_gap: assert property (reg_rd_in && reg_addr_in[7:5] == 3'h3 && reg_addr_in[3:0] == 4'h2
		|=> !reg_rdata_out[2]) else $error("gap");
	a_idhigh_load: assert property (load0_in ##1 reg_rd_in && reg_addr_in == 8'h61
		|=> reg_rdata_out == $past(rx_std_id_in[10:3], 2)) else $error("idh");
	a_idlow_fields: assert property (load1_in ##1 reg_rd_in && reg_addr_in == 8'h72
		|=> reg_rdata_out == $past({rx_std_id_in[2:0], rx_remote_in & ~rx_extended_in, rx_extended_in, 1'b0,
		rx_ext_id_in}, 2)) else $error("idl");
endmodule // rxbf_top_asserts
bind rxbf_top rxbf_top_asserts u_rxbf_top_asserts (.*);

/* tb/test_rxbf_top.sv */
`timescale 1ns/100ps
module test_rxbf_top;
	logic sys_clk_in = 0, reset_in = 1, reg_wr_in = 0, reg_rd_in = 0, load0_in = 0, load1_in = 0;
	logic release0_in = 0, release1_in = 0, rx_remote_in = 0, rx_extended_in = 0;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
	logic [10:0] rx_std_id_in = 11'h000;
	logic [17:16] rx_ext_id_in = 2'h0;
	wire [7:0] reg_rdata_out;
	wire buffer0_full_pin_out, buffer0_full_pin_oe_out, buffer1_full_pin_out, buffer1_full_pin_oe_out;
	wire [1:0] line;
	int num_errors = 0, samples_checked = 0;
	// Write data, readback, enables, line levels
	logic [19:0] rows [6] = '{20'h3c3cf, 20'h24246, 20'hff0ff, 20'h00003, 20'h1c1cd, 20'h31213};
	always #10 sys_clk_in = ~sys_clk_in;
	rxbf_top u_rxbf_top (.*);
	rxbf_host u_rxbf_host (.pin_in({buffer1_full_pin_out, buffer0_full_pin_out}),
		.oe_in({buffer1_full_pin_oe_out, buffer0_full_pin_oe_out}), .line_out(line));
	task chk(input logic [7:0] got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, d);
		{reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
		@(posedge sys_clk_in);
		reg_wr_in <= 0;
	endtask
	task rd(input logic [7:0] a, exp);
		{reg_addr_in, reg_rd_in} <= {a, 1'b1};
		@(posedge sys_clk_in);
		reg_rd_in <= 0;
		#1 chk(reg_rdata_out, exp);
		@(posedge sys_clk_in);
	endtask
	task pins(input logic [3:0] exp);
		// Pins trail a control write by two edges
		@(posedge sys_clk_in);
		#1 chk({4'h0, buffer1_full_pin_oe_out, buffer0_full_pin_oe_out, line}, {4'h0, exp});
		@(posedge sys_clk_in);
	endtask
	task ld(input logic b, input logic [14:0] f);
		{rx_std_id_in, rx_ext_id_in, rx_remote_in, rx_extended_in} <= f;
		{load1_in, load0_in} <= {b, !b};
		@(posedge sys_clk_in);
		{load1_in, load0_in} <= 2'h0;
	endtask
	task close_out;
		$display("checked %0d bad %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#20000;
		num_errors++;
		close_out;
	end
	initial
	begin
		repeat (16) @(posedge sys_clk_in);
		reset_in <= 0;
		pins(4'h3);
		rd(8'h0c, 8'h00);
		foreach (rows[i])
		begin
			wr(8'h0c, rows[i][19:12]);
			pins(rows[i][3:0]);
			rd(8'h0c, rows[i][11:4]);
			$display("row %0d done", i);
		end
		wr(8'h0c, 8'h0f);
		ld(1, 15'h0f07);
		rd(8'h72, 8'h09);
		pins(4'hd);
		ld(0, 15'h5a5a);
		rd(8'h61, 8'hb4);
		rd(8'h62, 8'hb2);
		pins(4'hc);
		{release1_in, release0_in} <= 2'h3;
		@(posedge sys_clk_in);
		{release1_in, release0_in} <= 2'h0;
		pins(4'hf);
		wr(8'h71, 8'hff);
		rd(8'h71, 8'h1e);
		rd(8'h55, 8'h00);
		// Load and release in one cycle: the load must win
		release0_in <= 1;
		ld(0, 15'h5a5a);
		release0_in <= 0;
		pins(4'he);
		$display("edge cases done");
		reset_in <= 1;
		repeat (2) @(posedge sys_clk_in);
		reset_in <= 0;
		pins(4'h3);
		rd(8'h0c, 8'h00);
		$display("reset test done");
		close_out;
	end
endmodule // test_rxbf_top
